// ---- verilog/ugp_regs.svh ----
// register offsets, field positions, reset values and sizes of the gpio block
//
// Notes on behaviour
// - The core logic advances at twice the resonator rate, one core tick per resonator edge (12 MHz from 6 MHz).
// - Every general purpose line of both ports can raise an interrupt request toward the core.
// - A line interrupt is caught on an edge, never a level, and software picks rising or falling per line.
// - Each line has its own pull-up, on only while software has set its one bit per line and the line's data bit releases the line.
// - Each line's sink current is set by software to one of sixteen levels with a four-bit field per line.
// - The high-current port has LED-capable drive on every implemented line, fixed in hardware, while the other port stays a low-current port.
// - Each port has eight lines, bit 0 to bit 7, and the small variant implements only bits 0 to 3 of the high-current port.
// - The timing pin is an open-drain output with a Schmitt input whose every rising edge raises a wake interrupt.
`ifndef UGP_REGS_SVH
`define UGP_REGS_SVH

`define UGP_ADDR_W 8
`define UGP_DATA_W 8
`define UGP_P1_LINES 8

`define UGP_OFS_P0_DATA 8'h00
`define UGP_OFS_P1_DATA 8'h01
`define UGP_OFS_P0_STAT 8'h02
`define UGP_OFS_P1_STAT 8'h03
`define UGP_OFS_P0_IE 8'h04
`define UGP_OFS_P1_IE 8'h05
`define UGP_OFS_P0_EDGE 8'h06
`define UGP_OFS_P1_EDGE 8'h07
`define UGP_OFS_P0_PU 8'h08
`define UGP_OFS_P1_PU 8'h09
`define UGP_OFS_TIMING 8'h22
`define UGP_OFS_ISINK_HI 4'h3

`define UGP_RST_DATA 8'hFF
`define UGP_RST_IE 8'h00
`define UGP_RST_EDGE 8'h00
`define UGP_RST_PU 8'h00
`define UGP_RST_ISINK 4'h0

`define UGP_TIM_DRIVE_BIT 0
`define UGP_TIM_WAKE_EN_BIT 1
`define UGP_TIM_WAKE_ST_BIT 2
`define UGP_TIM_LEVEL_BIT 3

`endif

// ---- verilog/ugp_pkg.sv ----
// types shared by the gpio block
package ugp_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ugp_bus_req_t;

  typedef logic [15:0][3:0] ugp_sink_t;

endpackage : ugp_pkg

// ---- verilog/ugp_line.sv ----
// one input line: synchroniser, edge detector and sticky status flag
`timescale 1ns/10ps
module ugp_line (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic rise_sel_in,
  input wire logic clear_in,
  output logic level_out,
  output logic status_out
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic status_reg;
  logic status_next;
  logic edge_seen;

  // =====================================================
  // edge detection and sticky flag
  always_comb begin
    edge_seen = rise_sel_in ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg);
    // set wins over a clear in the same cycle
    status_next = edge_seen | (status_reg & ~clear_in);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
      status_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      status_reg <= status_next;
    end
  end

  assign level_out = sync2_reg;
  assign status_out = status_reg;

endmodule : ugp_line

// ---- verilog/ugp_gpio.sv ----
// two gpio ports, timing pin, core tick doubler and register slave
`timescale 1ns/10ps
`include "ugp_regs.svh"
module ugp_gpio #(
  parameter int unsigned P1_LINES = `UGP_P1_LINES
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire ugp_pkg::ugp_bus_req_t bus_in,
  output logic [7:0] rd_data_out,
  input wire logic [7:0] low_current_port_lines_in,
  output logic [7:0] low_current_port_lines_out,
  output logic [7:0] low_current_port_lines_oe_out,
  output logic [7:0] low_current_port_pullup_en_out,
  input wire logic [7:0] high_current_port_lines_in,
  output logic [7:0] high_current_port_lines_out,
  output logic [7:0] high_current_port_lines_oe_out,
  output logic [7:0] high_current_port_pullup_en_out,
  output ugp_pkg::ugp_sink_t sink_level_out,
  output logic [15:0] high_drive_out,
  input wire logic timing_pin_in,
  output logic timing_pin_out,
  output logic timing_pin_oe_out,
  input wire logic resonator_input_in,
  output logic resonator_return_out,
  output logic core_tick_out,
  output logic irq_out
);

  // lines of the high-current port that exist in this variant
  localparam logic [7:0] P1_MASK = 8'((9'h001 << P1_LINES) - 9'h001);

  // =====================================================
  // per-line edge cells
  logic [15:0] pin_all;
  logic [15:0] level_all;
  logic [15:0] status_all;
  logic [15:0] clear_all;
  logic [15:0] rise_all;
  logic [7:0] p0_edge_reg;
  logic [7:0] p1_edge_reg;

  assign pin_all = {high_current_port_lines_in, low_current_port_lines_in};
  assign rise_all = {p1_edge_reg, p0_edge_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_line
      if (gi < 8 + P1_LINES) begin : g_impl
        ugp_line u_line (
          .ref_clk_in(ref_clk_in),
          .rst_n_in(rst_n_in),
          .pin_in(pin_all[gi]),
          .rise_sel_in(rise_all[gi]),
          .clear_in(clear_all[gi]),
          .level_out(level_all[gi]),
          .status_out(status_all[gi])
        );
      end else begin : g_absent
        assign level_all[gi] = 1'b0;
        assign status_all[gi] = 1'b0;
      end
    end
  endgenerate

  // =====================================================
  // timing pin with rising-edge wake flag
  logic tim_level;
  logic tim_status;
  logic tim_clear;

  ugp_line u_timing (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(timing_pin_in),
    .rise_sel_in(1'b1),
    .clear_in(tim_clear),
    .level_out(tim_level),
    .status_out(tim_status)
  );

  // =====================================================
  // register write decode
  logic [7:0] p0_data_reg;
  logic [7:0] p0_data_next;
  logic [7:0] p1_data_reg;
  logic [7:0] p1_data_next;
  logic [7:0] p0_ie_reg;
  logic [7:0] p0_ie_next;
  logic [7:0] p1_ie_reg;
  logic [7:0] p1_ie_next;
  logic [7:0] p0_edge_next;
  logic [7:0] p1_edge_next;
  logic [7:0] p0_pu_reg;
  logic [7:0] p0_pu_next;
  logic [7:0] p1_pu_reg;
  logic [7:0] p1_pu_next;
  logic tim_drive_reg;
  logic tim_drive_next;
  logic tim_wake_en_reg;
  logic tim_wake_en_next;
  ugp_pkg::ugp_sink_t isink_reg;
  ugp_pkg::ugp_sink_t isink_next;

  always_comb begin
    p0_data_next = p0_data_reg;
    p1_data_next = p1_data_reg;
    p0_ie_next = p0_ie_reg;
    p1_ie_next = p1_ie_reg;
    p0_edge_next = p0_edge_reg;
    p1_edge_next = p1_edge_reg;
    p0_pu_next = p0_pu_reg;
    p1_pu_next = p1_pu_reg;
    tim_drive_next = tim_drive_reg;
    tim_wake_en_next = tim_wake_en_reg;
    isink_next = isink_reg;
    clear_all = 16'h0000;
    tim_clear = 1'b0;
    if (bus_in.wr) begin
      case (bus_in.addr)
        `UGP_OFS_P0_DATA: p0_data_next = bus_in.wdata;
        `UGP_OFS_P1_DATA: p1_data_next = bus_in.wdata | ~P1_MASK;
        `UGP_OFS_P0_STAT: clear_all[7:0] = bus_in.wdata;
        `UGP_OFS_P1_STAT: clear_all[15:8] = bus_in.wdata;
        `UGP_OFS_P0_IE: p0_ie_next = bus_in.wdata;
        `UGP_OFS_P1_IE: p1_ie_next = bus_in.wdata & P1_MASK;
        `UGP_OFS_P0_EDGE: p0_edge_next = bus_in.wdata;
        `UGP_OFS_P1_EDGE: p1_edge_next = bus_in.wdata & P1_MASK;
        `UGP_OFS_P0_PU: p0_pu_next = bus_in.wdata;
        `UGP_OFS_P1_PU: p1_pu_next = bus_in.wdata & P1_MASK;
        `UGP_OFS_TIMING: begin
          tim_drive_next = bus_in.wdata[`UGP_TIM_DRIVE_BIT];
          tim_wake_en_next = bus_in.wdata[`UGP_TIM_WAKE_EN_BIT];
          tim_clear = bus_in.wdata[`UGP_TIM_WAKE_ST_BIT];
        end
        default: begin
          if (bus_in.addr[7:4] == `UGP_OFS_ISINK_HI) begin
            isink_next[bus_in.addr[3:0]] = bus_in.wdata[3:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      p0_data_reg <= `UGP_RST_DATA;
      p1_data_reg <= `UGP_RST_DATA;
      p0_ie_reg <= `UGP_RST_IE;
      p1_ie_reg <= `UGP_RST_IE;
      p0_edge_reg <= `UGP_RST_EDGE;
      p1_edge_reg <= `UGP_RST_EDGE;
      p0_pu_reg <= `UGP_RST_PU;
      p1_pu_reg <= `UGP_RST_PU;
      tim_drive_reg <= 1'b0;
      tim_wake_en_reg <= 1'b0;
      isink_reg <= {16{`UGP_RST_ISINK}};
    end else begin
      p0_data_reg <= p0_data_next;
      p1_data_reg <= p1_data_next;
      p0_ie_reg <= p0_ie_next;
      p1_ie_reg <= p1_ie_next;
      p0_edge_reg <= p0_edge_next;
      p1_edge_reg <= p1_edge_next;
      p0_pu_reg <= p0_pu_next;
      p1_pu_reg <= p1_pu_next;
      tim_drive_reg <= tim_drive_next;
      tim_wake_en_reg <= tim_wake_en_next;
      isink_reg <= isink_next;
    end
  end

  // =====================================================
  // read data, standing one cycle after the strobe only
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  always_comb begin
    rd_data_next = 8'h00;
    if (bus_in.rd) begin
      case (bus_in.addr)
        `UGP_OFS_P0_DATA: rd_data_next = level_all[7:0];
        `UGP_OFS_P1_DATA: rd_data_next = level_all[15:8] & P1_MASK;
        `UGP_OFS_P0_STAT: rd_data_next = status_all[7:0];
        `UGP_OFS_P1_STAT: rd_data_next = status_all[15:8];
        `UGP_OFS_P0_IE: rd_data_next = p0_ie_reg;
        `UGP_OFS_P1_IE: rd_data_next = p1_ie_reg;
        `UGP_OFS_P0_EDGE: rd_data_next = p0_edge_reg;
        `UGP_OFS_P1_EDGE: rd_data_next = p1_edge_reg;
        `UGP_OFS_P0_PU: rd_data_next = p0_pu_reg;
        `UGP_OFS_P1_PU: rd_data_next = p1_pu_reg;
        `UGP_OFS_TIMING: begin
          rd_data_next[`UGP_TIM_DRIVE_BIT] = tim_drive_reg;
          rd_data_next[`UGP_TIM_WAKE_EN_BIT] = tim_wake_en_reg;
          rd_data_next[`UGP_TIM_WAKE_ST_BIT] = tim_status;
          rd_data_next[`UGP_TIM_LEVEL_BIT] = tim_level;
        end
        default: begin
          if (bus_in.addr[7:4] == `UGP_OFS_ISINK_HI) begin
            rd_data_next = {4'h0, isink_reg[bus_in.addr[3:0]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_out = rd_data_reg;

  // =====================================================
  // interrupt request: enabled line flags and enabled wake flag
  logic irq_reg;
  logic irq_next;

  always_comb begin
    irq_next = (|(status_all & {p1_ie_reg, p0_ie_reg})) | (tim_status & tim_wake_en_reg);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_out = irq_reg;

  // =====================================================
  // core tick on every resonator edge, doubling the rate
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_prev_reg;
  logic tick_reg;
  logic tick_next;
  logic ret_reg;
  logic ret_next;

  always_comb begin
    tick_next = osc_s2_reg ^ osc_prev_reg;
    ret_next = ~osc_s2_reg;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      tick_reg <= 1'b0;
      ret_reg <= 1'b1;
    end else begin
      osc_s1_reg <= resonator_input_in;
      osc_s2_reg <= osc_s1_reg;
      osc_prev_reg <= osc_s2_reg;
      tick_reg <= tick_next;
      ret_reg <= ret_next;
    end
  end

  assign core_tick_out = tick_reg;
  assign resonator_return_out = ret_reg;

  // =====================================================
  // pad controls: a zero data bit sinks the line, a one releases it
  // registered from the next values so the pads change on the write edge with no decode glitch
  logic [7:0] lo_oe_reg;
  logic [7:0] lo_oe_next;
  logic [7:0] lo_pull_reg;
  logic [7:0] lo_pull_next;
  logic [7:0] hi_oe_reg;
  logic [7:0] hi_oe_next;
  logic [7:0] hi_pull_reg;
  logic [7:0] hi_pull_next;

  always_comb begin
    lo_oe_next = ~p0_data_next;
    lo_pull_next = p0_pu_next & p0_data_next;
    hi_oe_next = ~p1_data_next & P1_MASK;
    hi_pull_next = p1_pu_next & p1_data_next;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      lo_oe_reg <= ~`UGP_RST_DATA;
      lo_pull_reg <= `UGP_RST_PU & `UGP_RST_DATA;
      hi_oe_reg <= ~`UGP_RST_DATA & P1_MASK;
      hi_pull_reg <= `UGP_RST_PU & `UGP_RST_DATA;
    end else begin
      lo_oe_reg <= lo_oe_next;
      lo_pull_reg <= lo_pull_next;
      hi_oe_reg <= hi_oe_next;
      hi_pull_reg <= hi_pull_next;
    end
  end

  assign low_current_port_lines_out = 8'h00;
  assign low_current_port_lines_oe_out = lo_oe_reg;
  assign low_current_port_pullup_en_out = lo_pull_reg;
  assign high_current_port_lines_out = 8'h00;
  assign high_current_port_lines_oe_out = hi_oe_reg;
  assign high_current_port_pullup_en_out = hi_pull_reg;
  assign sink_level_out = isink_reg;
  assign high_drive_out = {P1_MASK, 8'h00};
  assign timing_pin_out = 1'b0;
  assign timing_pin_oe_out = tim_drive_reg;

endmodule : ugp_gpio

// ---- test/ugp_gpio_chk.sv ----
// port assertions of the gpio block
`timescale 1ns/10ps
module ugp_gpio_chk #(
  parameter int unsigned P1_LINES = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire ugp_pkg::ugp_bus_req_t bus_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [7:0] low_current_port_lines_out,
  input wire logic [7:0] low_current_port_lines_oe_out,
  input wire logic [7:0] low_current_port_pullup_en_out,
  input wire logic [7:0] high_current_port_lines_out,
  input wire logic [7:0] high_current_port_lines_oe_out,
  input wire logic [7:0] high_current_port_pullup_en_out,
  input wire logic [15:0] high_drive_out,
  input wire logic timing_pin_out,
  input wire logic resonator_input_in,
  input wire logic resonator_return_out,
  input wire logic core_tick_out
);
  localparam logic [7:0] HI_MASK = 8'((16'h0001 << P1_LINES) - 1);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ====================
  // assertions
  a_rd_idle_zero: assert property (!$past(bus_in.rd) |-> rd_data_out == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_read: assert property (bus_in.rd && bus_in.addr == 8'h40 |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_open_drain: assert property ((low_current_port_lines_out | high_current_port_lines_out) == 8'h00 && !timing_pin_out)
    else $error("pad driven high");
  a_pull_vs_sink: assert property (((low_current_port_pullup_en_out & low_current_port_lines_oe_out)
    | (high_current_port_pullup_en_out & high_current_port_lines_oe_out)) == 8'h00)
    else $error("pull-up on a sinking line");
  a_missing_lines: assert property (((high_current_port_lines_oe_out | high_current_port_pullup_en_out) & ~HI_MASK) == 8'h00)
    else $error("absent line active");
  a_drive_map: assert property (high_drive_out == {HI_MASK, 8'h00})
    else $error("drive strength map wrong");
  a_data_to_oe: assert property (bus_in.wr && bus_in.addr == 8'h00 ##1 !(bus_in.wr && bus_in.addr == 8'h00)
    |=> low_current_port_lines_oe_out == ~$past(bus_in.wdata, 2))
    else $error("sink enable does not follow data write");
  a_tick_pulse: assert property (core_tick_out |=> !core_tick_out)
    else $error("tick longer than one cycle");
  a_tick_cause: assert property ($changed(resonator_input_in) |-> ##[2:5] core_tick_out)
    else $error("no tick after resonator edge");
  a_return_inv: assert property ($stable(resonator_input_in) [*5] |-> resonator_return_out == !resonator_input_in)
    else $error("resonator return not inverted");
endmodule : ugp_gpio_chk

// ---- test/ugp_pads.sv ----
// switches, pad pull-ups and rc timing network around the gpio block
`timescale 1ns/10ps
module ugp_pads #(
  parameter int RC_CYCLES = 20
) (
  input wire logic ref_clk_in,
  input wire logic [15:0] sw_in,
  input wire logic [15:0] oe_in,
  input wire logic [15:0] pull_in,
  input wire logic tim_oe_in,
  output logic [15:0] pad_out,
  output logic tim_out
);
  logic flip_reg = 1'b0;
  int rc_reg = 0;
  // ====================
  // rc charge and float pattern
  always @(posedge ref_clk_in) begin
    flip_reg <= !flip_reg;
    rc_reg <= tim_oe_in ? 0 : (rc_reg < RC_CYCLES ? rc_reg + 1 : rc_reg);
  end
  // a released line without pull-up floats and wanders
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pad_out[i] = (sw_in[i] || oe_in[i]) ? 1'b0 : (pull_in[i] ? 1'b1 : flip_reg ^ i[0]);
    end
  end
  assign tim_out = !tim_oe_in && rc_reg >= RC_CYCLES;
endmodule : ugp_pads

// ---- test/tb.sv ----
// self-checking bench of the gpio block
`timescale 1ns/10ps
module tb;
  logic ref_clk_in, rst_n_in, timing_pin_in, timing_pin_out, timing_pin_oe_out;
  logic resonator_input_in, resonator_return_out, core_tick_out, irq_out;
  ugp_pkg::ugp_bus_req_t bus_in;
  ugp_pkg::ugp_sink_t sink_level_out;
  logic [7:0] rd_data_out, low_current_port_lines_in, low_current_port_lines_out, low_current_port_lines_oe_out;
  logic [7:0] low_current_port_pullup_en_out, high_current_port_lines_in, high_current_port_lines_out;
  logic [7:0] high_current_port_lines_oe_out, high_current_port_pullup_en_out;
  logic [15:0] high_drive_out, sw, pads;
  int n_mismatch = 0;
  int n_tests = 0;
  assign low_current_port_lines_in = pads[7:0];
  assign high_current_port_lines_in = pads[15:8];
  ugp_gpio u_dut (.ref_clk_in, .rst_n_in, .bus_in, .rd_data_out, .low_current_port_lines_in,
    .low_current_port_lines_out, .low_current_port_lines_oe_out, .low_current_port_pullup_en_out,
    .high_current_port_lines_in, .high_current_port_lines_out, .high_current_port_lines_oe_out,
    .high_current_port_pullup_en_out, .sink_level_out, .high_drive_out, .timing_pin_in, .timing_pin_out,
    .timing_pin_oe_out, .resonator_input_in, .resonator_return_out, .core_tick_out, .irq_out);
  ugp_pads u_pads (.ref_clk_in, .sw_in(sw), .tim_oe_in(timing_pin_oe_out), .pad_out(pads), .tim_out(timing_pin_in),
    .oe_in({high_current_port_lines_oe_out, low_current_port_lines_oe_out}),
    .pull_in({high_current_port_pullup_en_out, low_current_port_pullup_en_out}));
  // small variant on the same bus: only four high-current lines exist
  logic [7:0] s_hi_oe, s_hi_pu;
  logic [15:0] s_drive;
  ugp_gpio #(.P1_LINES(4)) u_small (.ref_clk_in, .rst_n_in, .bus_in, .rd_data_out(), .low_current_port_lines_in,
    .low_current_port_lines_out(), .low_current_port_lines_oe_out(), .low_current_port_pullup_en_out(),
    .high_current_port_lines_in, .high_current_port_lines_out(), .high_current_port_lines_oe_out(s_hi_oe),
    .high_current_port_pullup_en_out(s_hi_pu), .sink_level_out(), .high_drive_out(s_drive), .timing_pin_in,
    .timing_pin_out(), .timing_pin_oe_out(), .resonator_input_in, .resonator_return_out(), .core_tick_out(),
    .irq_out());
  // ====================
  // clock, resonator and tasks
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = !ref_clk_in;
  end
  always begin
    repeat (10) @(posedge ref_clk_in);
    if (rst_n_in) resonator_input_in <= !resonator_input_in;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_in <= '0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_in <= '0;
    #1;
    chk("rd_data", 16'(rd_data_out), 16'(e));
  endtask : rdc
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : wt
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // ====================
  // scenarios
  task automatic t_reset;
    chk("oe", {high_current_port_lines_oe_out, low_current_port_lines_oe_out}, 16'h0000);
    chk("pull", {high_current_port_pullup_en_out, low_current_port_pullup_en_out}, 16'h0000);
    chk("drive", high_drive_out, 16'hFF00);
    for (int a = 4; a < 10; a++) rdc(8'(a), 8'h00);
    rdc(8'h40, 8'h00);
    wr(8'h08, 8'hFF);
    wr(8'h09, 8'hFF);
    wr(8'h22, 8'h04);
    wt(4);
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'hFF);
    chk("irq", 16'(irq_out), 16'h0000);
  endtask : t_reset
  task automatic t_drive;
    wr(8'h01, 8'h5A);
    wr(8'h00, 8'hC3);
    wr(8'h08, 8'h0F);
    wt(2);
    chk("hi_oe", 16'(high_current_port_lines_oe_out), 16'h00A5);
    chk("lo_oe", 16'(low_current_port_lines_oe_out), 16'h003C);
    chk("hi_pull", 16'(high_current_port_pullup_en_out), 16'h005A);
    chk("lo_pull", 16'(low_current_port_pullup_en_out), 16'h0003);
    chk("small_oe", 16'(s_hi_oe), 16'h0005);
    chk("small_pull", 16'(s_hi_pu), 16'h000A);
    chk("small_drive", s_drive, 16'h0F00);
    rdc(8'h01, 8'h5A);
    wr(8'h01, 8'hFF);
    wr(8'h00, 8'hFF);
    wr(8'h08, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      wr(8'h30 + 8'(i), 8'(i));
      wt(2);
      chk("sink", 16'(sink_level_out[i]), 16'(i));
    end
    rdc(8'h3F, 8'h0F);
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'hFF);
  endtask : t_drive
  task automatic t_lines;
    logic [7:0] b;
    logic [7:0] o;
    for (int i = 0; i < 16; i++) begin
      b = 8'h01 << (i % 8);
      o = 8'(i / 8);
      wr(8'h04 + o, b);
      sw[i] <= 1'b1;
      wt(6);
      chk("irq", 16'(irq_out), 16'h0001);
      rdc(8'h02 + o, b);
      wr(8'h02 + o, b);
      sw[i] <= 1'b0;
      wt(6);
      chk("irq", 16'(irq_out), 16'h0000);
      rdc(8'h02 + o, 8'h00);
      wr(8'h04 + o, 8'h00);
    end
    wr(8'h07, 8'h02);
    sw[9] <= 1'b1;
    wt(6);
    sw[9] <= 1'b0;
    wt(6);
    chk("irq", 16'(irq_out), 16'h0000);
    rdc(8'h03, 8'h02);
    wr(8'h05, 8'h02);
    wt(2);
    chk("irq", 16'(irq_out), 16'h0001);
    wr(8'h03, 8'h02);
    wr(8'h05, 8'h00);
  endtask : t_lines
  task automatic t_wake;
    int cnt;
    wr(8'h22, 8'h03);
    wt(2);
    chk("tim_oe", 16'(timing_pin_oe_out), 16'h0001);
    wr(8'h22, 8'h02);
    wt(30);
    chk("irq", 16'(irq_out), 16'h0001);
    rdc(8'h22, 8'h0E);
    wr(8'h22, 8'h06);
    wt(2);
    chk("irq", 16'(irq_out), 16'h0000);
    cnt = 0;
    repeat (200) begin
      wt(1);
      cnt += int'(core_tick_out);
    end
    chk("ticks", 16'(cnt >= 19 && cnt <= 21), 16'h0001);
  endtask : t_wake
  initial begin
    bus_in = '0;
    sw = '0;
    rst_n_in = 1'b0;
    resonator_input_in = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    wt(1);
    t_reset();
    t_drive();
    t_lines();
    t_wake();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb
bind ugp_gpio ugp_gpio_chk #(.P1_LINES(P1_LINES)) u_chk (.ref_clk_in, .rst_n_in, .bus_in, .rd_data_out,
  .low_current_port_lines_out, .low_current_port_lines_oe_out, .low_current_port_pullup_en_out,
  .high_current_port_lines_out, .high_current_port_lines_oe_out, .high_current_port_pullup_en_out,
  .high_drive_out, .timing_pin_out, .resonator_input_in, .resonator_return_out, .core_tick_out);
